// *** src/opcode_page_and_operand_decoder.sv ***
// Opcode page prefix recogniser and operand address former
`timescale 1ns/1ps
`include "opdec_consts.svh"
module opcode_page_and_operand_decoder (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic FETCH_VALID,
  input wire logic [7:0] FETCH_BYTE,
  output logic FETCH_READY,
  input wire logic PC_LOAD,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] IX_VAL,
  input wire logic [15:0] IY_VAL,
  output logic OP_VALID,
  output logic [7:0] OP_CODE,
  output logic [1:0] OP_PAGE,
  input wire logic MODE_VALID,
  input wire logic [2:0] MODE_SEL,
  input wire logic LIT_WIDE,
  input wire logic BRANCH_TAKEN,
  output logic DEC_DONE,
  output logic [2:0] DEC_MODE,
  output logic [15:0] EFF_ADDR,
  output logic [15:0] OPERAND,
  output logic MEM_ACCESS,
  output logic [2:0] INSTR_LEN,
  output logic [15:0] PC_OUT
);
  ea_if ea ();
  ea_adder u_adder (.bus(ea));

  opdec_pkg::state_t state_q, state_d;
  opdec_pkg::mode_t mode_q, mode_d;
  logic ready_q, ready_d;
  logic opv_q, opv_d;
  logic [7:0] opc_q, opc_d;
  logic [1:0] page_q, page_d;
  logic done_q, done_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] opnd_q, opnd_d;
  logic mem_q, mem_d;
  logic [2:0] len_q, len_d;
  logic [15:0] pc_q, pc_d;
  logic [1:0] need_q, need_d;
  logic take;
  logic [1:0] need_now;

  assign take = FETCH_VALID & ready_q;

  // Adder operand selection
  always_comb begin
    ea.offset = opnd_q[7:0];
    ea.sign_ext = (mode_q == opdec_pkg::branch_offset_mode);
    case (mode_q)
      opdec_pkg::x_offset_mode: ea.base = IX_VAL;
      opdec_pkg::y_offset_mode: ea.base = IY_VAL;
      default: ea.base = pc_q;
    endcase
  end

  // Operand byte count for the mode just given
  always_comb begin
    case (opdec_pkg::mode_t'(MODE_SEL))
      opdec_pkg::literal_operand_mode: need_now = LIT_WIDE ? 2'd2 : 2'd1;
      opdec_pkg::zero_page_mode: need_now = 2'd1;
      opdec_pkg::full_address_mode: need_now = 2'd2;
      opdec_pkg::x_offset_mode: need_now = 2'd1;
      opdec_pkg::y_offset_mode: need_now = 2'd1;
      opdec_pkg::branch_offset_mode: need_now = 2'd1;
      default: need_now = 2'd0;
    endcase
  end

  // Next state and outputs
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    opv_d = 1'b0;
    opc_d = opc_q;
    page_d = page_q;
    done_d = 1'b0;
    ea_d = ea_q;
    opnd_d = opnd_q;
    mem_d = mem_q;
    len_d = len_q;
    need_d = need_q;
    pc_d = take ? pc_q + 16'h0001 : pc_q;
    case (state_q)
      opdec_pkg::ST_FIRST: begin
        if (take) begin
          opnd_d = 16'h0000;
          len_d = 3'd1;
          if (FETCH_BYTE == `PREFIX_PAGE2) begin
            page_d = `PAGE_TWO;
            state_d = opdec_pkg::ST_OPCODE;
          end else if (FETCH_BYTE == `PREFIX_PAGE3) begin
            page_d = `PAGE_THREE;
            state_d = opdec_pkg::ST_OPCODE;
          end else if (FETCH_BYTE == `PREFIX_PAGE4) begin
            page_d = `PAGE_FOUR;
            state_d = opdec_pkg::ST_OPCODE;
          end else begin
            page_d = `PAGE_ONE;
            opc_d = FETCH_BYTE;
            opv_d = 1'b1;
            state_d = opdec_pkg::ST_MODE;
          end
        end
      end
      opdec_pkg::ST_OPCODE: begin
        // Only the byte right after a prefix is decoded on that page
        if (take) begin
          opc_d = FETCH_BYTE;
          opv_d = 1'b1;
          len_d = len_q + 3'd1;
          state_d = opdec_pkg::ST_MODE;
        end
      end
      opdec_pkg::ST_MODE: begin
        if (MODE_VALID) begin
          mode_d = opdec_pkg::mode_t'(MODE_SEL);
          if (MODE_SEL > 3'b110) begin
            mode_d = opdec_pkg::register_only_mode;
          end
          need_d = need_now;
          len_d = len_q + {1'b0, need_now};
          if (need_now != 2'd0) begin
            state_d = opdec_pkg::ST_OPERAND;
          end else begin
            state_d = opdec_pkg::ST_FINISH;
          end
        end
      end
      opdec_pkg::ST_OPERAND: begin
        if (take) begin
          opnd_d = {opnd_q[7:0], FETCH_BYTE};
          need_d = need_q - 2'd1;
          if (need_q == 2'd1) begin
            if (mode_q == opdec_pkg::y_offset_mode) begin
              state_d = opdec_pkg::ST_YSTALL;
            end else begin
              state_d = opdec_pkg::ST_FINISH;
            end
          end
        end
      end
      opdec_pkg::ST_YSTALL: begin
        state_d = opdec_pkg::ST_FINISH;
      end
      opdec_pkg::ST_FINISH: begin
        done_d = 1'b1;
        mem_d = 1'b1;
        ea_d = 16'h0000;
        case (mode_q)
          opdec_pkg::literal_operand_mode: mem_d = 1'b0;
          opdec_pkg::zero_page_mode: ea_d = {`ZERO_PAGE_HIGH, opnd_q[7:0]};
          opdec_pkg::full_address_mode: ea_d = opnd_q;
          opdec_pkg::x_offset_mode: ea_d = ea.sum;
          opdec_pkg::y_offset_mode: ea_d = ea.sum;
          opdec_pkg::branch_offset_mode: begin
            mem_d = 1'b0;
            ea_d = BRANCH_TAKEN ? ea.sum : pc_q;
            pc_d = BRANCH_TAKEN ? ea.sum : pc_q;
          end
          default: mem_d = 1'b0;
        endcase
        page_d = `PAGE_ONE;
        state_d = opdec_pkg::ST_FIRST;
      end
      default: state_d = opdec_pkg::ST_FIRST;
    endcase
    if (PC_LOAD) begin
      pc_d = PC_IN;
    end
    ready_d = (state_d == opdec_pkg::ST_FIRST) || (state_d == opdec_pkg::ST_OPCODE)
           || ((state_d == opdec_pkg::ST_OPERAND) && (need_d != 2'd0));
  end

  // State registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= opdec_pkg::ST_FIRST;
      mode_q <= opdec_pkg::register_only_mode;
      ready_q <= 1'b0;
      opv_q <= 1'b0;
      opc_q <= 8'h00;
      page_q <= `PAGE_ONE;
      done_q <= 1'b0;
      ea_q <= 16'h0000;
      opnd_q <= 16'h0000;
      mem_q <= 1'b0;
      len_q <= 3'd0;
      pc_q <= `PC_RESET;
      need_q <= 2'd0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      ready_q <= ready_d;
      opv_q <= opv_d;
      opc_q <= opc_d;
      page_q <= page_d;
      done_q <= done_d;
      ea_q <= ea_d;
      opnd_q <= opnd_d;
      mem_q <= mem_d;
      len_q <= len_d;
      pc_q <= pc_d;
      need_q <= need_d;
    end
  end

  // Outputs straight from flops
  assign FETCH_READY = ready_q;
  assign OP_VALID = opv_q;
  assign OP_CODE = opc_q;
  assign OP_PAGE = page_q;
  assign DEC_DONE = done_q;
  assign DEC_MODE = mode_q;
  assign EFF_ADDR = ea_q;
  assign OPERAND = opnd_q;
  assign MEM_ACCESS = mem_q;
  assign INSTR_LEN = len_q;
  assign PC_OUT = pc_q;
endmodule : opcode_page_and_operand_decoder

// *** src/opdec_consts.svh ***
// Constants for the opcode page and operand decoder
`ifndef OPDEC_CONSTS_SVH
`define OPDEC_CONSTS_SVH
`define PREFIX_PAGE2 8'h18
`define PREFIX_PAGE3 8'h1a
`define PREFIX_PAGE4 8'hcd
`define PAGE_ONE 2'h0
`define PAGE_TWO 2'h1
`define PAGE_THREE 2'h2
`define PAGE_FOUR 2'h3
`define ZERO_PAGE_HIGH 8'h00
`define PC_RESET 16'h0000
`define Y_EXTRA_CYCLES 1
`endif

// *** src/opdec_pkg.sv ***
// Types shared by the decoder modules
`include "opdec_consts.svh"
package opdec_pkg;
  // Operand modes as presented by the datapath
  typedef enum logic [2:0] {
    literal_operand_mode = 3'b000,
    zero_page_mode = 3'b001,
    full_address_mode = 3'b010,
    x_offset_mode = 3'b011,
    y_offset_mode = 3'b100,
    register_only_mode = 3'b101,
    branch_offset_mode = 3'b110
  } mode_t;
  // Decoder sequence
  typedef enum logic [2:0] {
    ST_FIRST = 3'b000,
    ST_OPCODE = 3'b001,
    ST_MODE = 3'b010,
    ST_OPERAND = 3'b011,
    ST_YSTALL = 3'b100,
    ST_FINISH = 3'b101
  } state_t;
endpackage : opdec_pkg

// *** src/ea_if.sv ***
// Carrier between the decoder and its address adder
`timescale 1ns/1ps
interface ea_if;
  logic [15:0] base;
  logic [7:0] offset;
  logic sign_ext;
  logic [15:0] sum;
  modport requester (output base, output offset, output sign_ext, input sum);
  modport adder (input base, input offset, input sign_ext, output sum);
endinterface : ea_if

// *** src/ea_adder.sv ***
// Effective address adder, 16-bit wrap
`timescale 1ns/1ps
module ea_adder (
  ea_if.adder bus
);
  logic [15:0] ext_off;
  // Zero or sign extend the offset byte
  always_comb begin
    ext_off = {{8{bus.sign_ext & bus.offset[7]}}, bus.offset};
    bus.sum = bus.base + ext_off;
  end
endmodule : ea_adder

// *** dv/opdec_monitor.sv ***
// Assertion checker for the opcode page and operand decoder
`timescale 1ns/1ps
module opdec_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic FETCH_VALID,
  input wire logic FETCH_READY,
  input wire logic PC_LOAD,
  input wire logic [15:0] IX_VAL,
  input wire logic [15:0] IY_VAL,
  input wire logic BRANCH_TAKEN,
  input wire logic OP_VALID,
  input wire logic [1:0] OP_PAGE,
  input wire logic DEC_DONE,
  input wire logic [2:0] DEC_MODE,
  input wire logic [15:0] EFF_ADDR,
  input wire logic [15:0] OPERAND,
  input wire logic MEM_ACCESS,
  input wire logic [15:0] PC_OUT
);
  logic [3:0] dm;
  // Done flag joined to the mode
  assign dm = {DEC_DONE, DEC_MODE};
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_done_pulse: assert property (DEC_DONE |=> !DEC_DONE)
    else $error("done held");
  a_page_clear: assert property (DEC_DONE |-> OP_PAGE == 2'h0)
    else $error("page kept");
  a_zero_high: assert property (
    dm == 4'h9 |-> EFF_ADDR[15:8] == 8'h00 && MEM_ACCESS)
    else $error("zero page high");
  a_literal_quiet: assert property (
    dm == 4'h8 |-> !MEM_ACCESS && EFF_ADDR == 16'h0000)
    else $error("literal access");
  a_reg_quiet: assert property (dm == 4'hd |-> !MEM_ACCESS)
    else $error("register-only access");
  a_x_sum: assert property (
    dm == 4'hb |-> EFF_ADDR == IX_VAL + OPERAND[7:0])
    else $error("x sum");
  a_y_sum: assert property (dm == 4'hc |-> EFF_ADDR == IY_VAL + OPERAND[7:0])
    else $error("y sum");
  a_branch_pc: assert property (
    dm == 4'he && $past(BRANCH_TAKEN) && !$past(PC_LOAD) |-> PC_OUT == EFF_ADDR)
    else $error("branch pc");
  a_pc_step: assert property (
    FETCH_VALID && FETCH_READY && !PC_LOAD |=> PC_OUT == $past(PC_OUT) + 16'h1)
    else $error("pc step");
  // Main scenarios reached
  c_y: cover property (dm == 4'hc);
  c_branch: cover property (dm == 4'he && PC_OUT == EFF_ADDR);
  c_page4: cover property (OP_VALID && OP_PAGE == 2'h3);
endmodule : opdec_monitor
bind opcode_page_and_operand_decoder opdec_monitor mon (
  .SYS_CLK(SYS_CLK),
  .RST(RST),
  .FETCH_VALID(FETCH_VALID),
  .FETCH_READY(FETCH_READY),
  .PC_LOAD(PC_LOAD),
  .IX_VAL(IX_VAL),
  .IY_VAL(IY_VAL),
  .BRANCH_TAKEN(BRANCH_TAKEN),
  .OP_VALID(OP_VALID),
  .OP_PAGE(OP_PAGE),
  .DEC_DONE(DEC_DONE),
  .DEC_MODE(DEC_MODE),
  .EFF_ADDR(EFF_ADDR),
  .OPERAND(OPERAND),
  .MEM_ACCESS(MEM_ACCESS),
  .PC_OUT(PC_OUT)
);

// *** dv/fetch_memory.sv ***
// Instruction stream model feeding the fetch port
`timescale 1ns/1ps
module fetch_memory (
  input wire logic SYS_CLK,
  input wire logic FETCH_READY,
  output logic FETCH_VALID,
  output logic [7:0] FETCH_BYTE
);
  logic [7:0] q[$];
  logic [7:0] last = 8'h00;
  logic slow = 1'b0;
  logic gap = 1'b0;
  initial FETCH_VALID = 1'b0;
  initial FETCH_BYTE = 8'h00;
  // Byte leaves the queue when taken
  always @(posedge SYS_CLK) begin
    if (FETCH_VALID && FETCH_READY) last = q.pop_front();
  end
  // Offer next byte; scrambled when idle, every other cycle when slow
  always @(negedge SYS_CLK) begin
    gap = slow && !gap;
    FETCH_VALID <= (q.size() != 0) && !gap;
    FETCH_BYTE <= (q.size() != 0 && !gap) ? q[0] : ~last;
  end
endmodule : fetch_memory

// *** dv/testbench.sv ***
// Self-checking testbench for the opcode page and operand decoder
`timescale 1ns/1ps
module testbench;
  logic SYS_CLK = 1'b0, RST = 1'b1, PC_LOAD = 1'b0, MODE_VALID = 1'b0;
  logic LIT_WIDE = 1'b0, BRANCH_TAKEN = 1'b0, FETCH_VALID, FETCH_READY;
  logic OP_VALID, DEC_DONE, MEM_ACCESS;
  logic [7:0] FETCH_BYTE, OP_CODE, opc;
  logic [1:0] OP_PAGE, page;
  logic [2:0] MODE_SEL = 3'h0, DEC_MODE, INSTR_LEN;
  logic [15:0] PC_IN = 16'h0000, IX_VAL = 16'hff80, IY_VAL = 16'h2000;
  logic [15:0] EFF_ADDR, OPERAND, PC_OUT;
  int err_count = 0, n_checks = 0, cyc;
  always #2 SYS_CLK = ~SYS_CLK;
  opcode_page_and_operand_decoder DUT (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .FETCH_VALID(FETCH_VALID),
    .FETCH_BYTE(FETCH_BYTE),
    .FETCH_READY(FETCH_READY),
    .PC_LOAD(PC_LOAD),
    .PC_IN(PC_IN),
    .IX_VAL(IX_VAL),
    .IY_VAL(IY_VAL),
    .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE),
    .OP_PAGE(OP_PAGE),
    .MODE_VALID(MODE_VALID),
    .MODE_SEL(MODE_SEL),
    .LIT_WIDE(LIT_WIDE),
    .BRANCH_TAKEN(BRANCH_TAKEN),
    .DEC_DONE(DEC_DONE),
    .DEC_MODE(DEC_MODE),
    .EFF_ADDR(EFF_ADDR),
    .OPERAND(OPERAND),
    .MEM_ACCESS(MEM_ACCESS),
    .INSTR_LEN(INSTR_LEN),
    .PC_OUT(PC_OUT)
  );
  fetch_memory mem (
    .SYS_CLK(SYS_CLK),
    .FETCH_READY(FETCH_READY),
    .FETCH_VALID(FETCH_VALID),
    .FETCH_BYTE(FETCH_BYTE)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // Feed bytes, answer with a mode, wait for the result
  task automatic decode(input logic [2:0] m, input logic [7:0] b[$]);
    int i;
    mem.q = b;
    for (i = 0; i < 50 && OP_VALID !== 1'b1; i++) @(posedge SYS_CLK) #1;
    page = OP_PAGE;
    opc = OP_CODE;
    @(negedge SYS_CLK) MODE_VALID = 1'b1;
    MODE_SEL = m;
    @(negedge SYS_CLK) MODE_VALID = 1'b0;
    for (cyc = 1; cyc < 50 && DEC_DONE !== 1'b1; cyc++) @(posedge SYS_CLK) #1;
    if (i == 50 || cyc == 50) begin
      err_count++;
      results();
    end
    check(DEC_MODE, m == 3'h7 ? 3'h5 : m);
  endtask : decode
  // Prefixed wide literal, then a plain narrow one
  task automatic t_literal;
    @(negedge SYS_CLK) LIT_WIDE = 1'b1;
    decode(3'h0, '{8'h18, 8'hce, 8'h12, 8'h34});
    check(page, 2'h1);
    check(opc, 8'hce);
    check(OPERAND, 16'h1234);
    check(INSTR_LEN, 3'h4);
    check(MEM_ACCESS, 1'b0);
    @(negedge SYS_CLK) LIT_WIDE = 1'b0;
    decode(3'h0, '{8'h86, 8'h5a});
    check(page, 2'h0);
    check(opc, 8'h86);
    check(OPERAND, 16'h005a);
    check(INSTR_LEN, 3'h2);
  endtask : t_literal
  // Zero page, then full address with a slow stream
  task automatic t_memory;
    decode(3'h1, '{8'h96, 8'hab});
    check(EFF_ADDR, 16'h00ab);
    check(MEM_ACCESS, 1'b1);
    mem.slow = 1'b1;
    decode(3'h2, '{8'hb6, 8'hbe, 8'hef});
    mem.slow = 1'b0;
    check(EFF_ADDR, 16'hbeef);
    check(OPERAND, 16'hbeef);
    check(INSTR_LEN, 3'h3);
    check(MEM_ACCESS, 1'b1);
  endtask : t_memory
  // Both index registers, wrap and extra cycle
  task automatic t_index;
    int xc;
    decode(3'h3, '{8'ha6, 8'hff});
    xc = cyc;
    check(EFF_ADDR, 16'h007f);
    check(INSTR_LEN, 3'h2);
    check(MEM_ACCESS, 1'b1);
    decode(3'h4, '{8'h18, 8'ha6, 8'hff});
    check(EFF_ADDR, 16'h20ff);
    check(INSTR_LEN, 3'h3);
    check(16'(cyc), 16'(xc + 1));
  endtask : t_index
  // Every prefix on register-only opcodes
  task automatic t_pages;
    logic [7:0] pre[3] = '{8'h18, 8'h1a, 8'hcd};
    for (int k = 0; k < 3; k++) begin
      decode(3'h5, '{pre[k], 8'h3c});
      check(page, 16'(k + 1));
      check(opc, 8'h3c);
      check(MEM_ACCESS, 1'b0);
      check(FETCH_READY, 1'b1);
    end
    decode(3'h7, '{8'h4f});
    check(INSTR_LEN, 3'h1);
    check(page, 2'h0);
  endtask : t_pages
  // Backward branch not taken, then taken
  task automatic t_branch;
    for (int k = 0; k < 2; k++) begin
      @(negedge SYS_CLK) PC_LOAD = 1'b1;
      PC_IN = 16'h1000;
      @(negedge SYS_CLK) PC_LOAD = 1'b0;
      BRANCH_TAKEN = k[0];
      decode(3'h6, '{8'h20, 8'hf0});
      check(PC_OUT, k ? 16'h0ff2 : 16'h1002);
    end
    check(EFF_ADDR, 16'h0ff2);
    @(negedge SYS_CLK) BRANCH_TAKEN = 1'b0;
  endtask : t_branch
  // Reset, then the scenarios in turn
  initial begin
    repeat (5) @(negedge SYS_CLK);
    RST = 1'b0;
    check(PC_OUT, 16'h0000);
    @(posedge SYS_CLK) #1;
    check(FETCH_READY, 1'b1);
    t_literal();
    t_memory();
    t_index();
    t_pages();
    t_branch();
    results();
  end
endmodule : testbench
